// File: hw/cpm_pkg.sv
// Operation
// R1: Compatibility control register at I/O 3Eh
// R2: Fetch strobe enable set at reset; strobes fetches
// R3: Enabled: return-from-irq fetched once, three clocks
// R4: Disabled: no strobe; refetch return with strobe
// R5: One-shot bit resets to one, reads one
// R6: Writing zero strobes next fetch only
// R7: I/O timing select set at reset, newer timing
// R8: Select zero: I/O strobes at second state rise
// R9: Normal operation keeps halt output high
// R10: Halt: refetch opcode, drive halt/status/strobe low
// R11: Halt keeps clock, interrupts, grants, refresh, peripherals
// R12: Halt exits on reset, interrupts, nonmaskable request
// R13: Sleep entered when freeze and control bits zero
// R14: Sleep gates core clock, stops refresh, holds bus high
// R15: Sleep wakes on enabled sources only
// R16: Wake with global enable one: service interrupt
// R17: Wake with global enable zero: continue onward
// R18: Resume about one and half clocks after wake
// R19: Freeze bit stops serial and timer units
// R20: Sleep with freeze stops all, clock output runs
package cpm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CPM_CTRL_ADDR = 8'h3e;
  localparam int CPM_BIT_FETCH_EN = 7;
  localparam int CPM_BIT_ONE_SHOT = 6;
  localparam int CPM_BIT_IO_TIMING = 5;
  localparam logic [7:0] CPM_CTRL_RESET = 8'he0;
  localparam logic [7:0] CPM_CTRL_RSVD_READ = 8'h1f;
  localparam int CPM_BIT_FREEZE = 5;
  localparam int CPM_BIT_CPU_CTRL3 = 3;
  localparam int CPM_BIT_CPU_CTRL6 = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CPM_CLOCK_MHZ = 250;
  localparam int CPM_WAKE_HALF_CLOCKS = 3;
  localparam logic [1:0] CPM_WAKE_CYCLES = 2'((CPM_WAKE_HALF_CLOCKS + 1) / 2);

  // ****************************************
  // Power modes
  // ****************************************
  typedef enum logic [4:0] {
    CPM_NORMAL = 5'h01,
    CPM_HALT = 5'h02,
    CPM_SLEEP = 5'h04,
    CPM_WAKE = 5'h08,
    CPM_STOP = 5'h10
  } cpm_mode_type;
endpackage : cpm_pkg

// File: hw/cpm_fetch_strobe.sv
module cpm_fetch_strobe
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_fetch_strobe_enable,
  input wire logic i_one_shot_arm,
  input wire logic i_halted,
  // Cycle info
  input wire logic i_opcode_fetch,
  input wire logic i_irq0_ack,
  input wire logic i_nmi_ack_first,
  input wire logic i_ret_irq_fetch,
  input wire logic i_cycle_start,
  // Results
  output logic o_strobe_n,
  output logic o_ret_irq_refetch
);
  // ****************************************
  // Strobe decision
  // ****************************************
  logic one_shot_reg;
  logic refetch_reg;
  logic want;

  // One-shot pending until next opcode fetch
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      one_shot_reg <= 1'b0;
    end else if (i_one_shot_arm) begin
      one_shot_reg <= 1'b1; // R6
    end else if (i_cycle_start && i_opcode_fetch) begin
      one_shot_reg <= 1'b0;
    end
  end

  // Legacy refetch follows a disabled-strobe return fetch
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      refetch_reg <= 1'b0;
    end else if (i_cycle_start && i_ret_irq_fetch && !i_fetch_strobe_enable && !refetch_reg) begin
      refetch_reg <= 1'b1; // R4
    end else if (i_cycle_start && i_opcode_fetch) begin
      refetch_reg <= 1'b0; // R3
    end
  end

  always_comb begin
    want = i_halted; // R10
    if (i_fetch_strobe_enable && (i_opcode_fetch || i_irq0_ack || i_nmi_ack_first)) begin
      want = 1'b1; // R2
    end
    if ((one_shot_reg || refetch_reg) && i_opcode_fetch) begin
      want = 1'b1; // R4 R6
    end
  end

  // Registered, low while the cycle qualifies
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_strobe_n <= 1'b1;
    end else begin
      o_strobe_n <= ~want;
    end
  end

  assign o_ret_irq_refetch = refetch_reg;
endmodule : cpm_fetch_strobe

// File: hw/cpm_io_timing.sv
module cpm_io_timing
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_io_timing_select,
  // Bus state
  input wire logic i_io_read,
  input wire logic i_state_t1_late,
  input wire logic i_second_bus_state,
  // Strobes
  output logic o_io_active
);
  // ****************************************
  // I/O strobe timing
  // ****************************************
  // Newer timing opens a state early; legacy waits for second state rise
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_io_active <= 1'b0;
    end else if (!i_io_read) begin
      o_io_active <= 1'b0;
    end else if (i_io_timing_select) begin
      o_io_active <= o_io_active | i_state_t1_late; // R7
    end else begin
      o_io_active <= o_io_active | i_second_bus_state; // R8
    end
  end
endmodule : cpm_io_timing

// File: hw/cpm_ctrl.sv
module cpm_ctrl
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // I/O register port
  input wire logic [7:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_write,
  input wire logic i_io_read,
  output logic [7:0] o_io_rdata,
  // Other control bits
  input wire logic [7:0] i_io_control,
  input wire logic [7:0] i_cpu_control,
  input wire logic i_global_irq_enable_flag,
  // Core events
  input wire logic i_halt_exec,
  input wire logic i_sleep_exec,
  input wire logic i_bus_granted,
  // Wake sources (on-chip and NMI masked upstream; external masked by i_ext_irq_en)
  input wire logic i_onchip_irq,
  input wire logic i_nmi_req,
  input wire logic [2:0] i_ext_irq,
  input wire logic [2:0] i_ext_irq_en,
  // Bus cycle info
  input wire logic i_opcode_fetch,
  input wire logic i_irq0_ack,
  input wire logic i_nmi_ack_first,
  input wire logic i_ret_irq_fetch,
  input wire logic i_cycle_start,
  input wire logic i_bus_io_read,
  input wire logic i_state_t1_late,
  input wire logic i_second_bus_state,
  // Pins and enables
  output logic o_fetch_cycle_strobe_n,
  output logic o_io_request_strobe_n,
  output logic o_read_strobe_n,
  output logic o_halt_n,
  output logic o_status_output,
  output logic o_bus_hold_high,
  output logic o_core_clk_en,
  output logic o_dma_clk_en,
  output logic o_refresh_en,
  output logic o_periph_clk_en,
  output logic o_clock_out_en,
  output logic o_ret_irq_refetch,
  output logic o_wake_take_irq,
  output logic o_wake_continue
);
  // ****************************************
  // Compatibility register
  // ****************************************
  logic fetch_strobe_enable_reg;
  logic io_timing_select_reg;
  logic one_shot_arm;
  logic ctrl_hit;
  logic strobe_n;
  logic io_active;
  logic wake_src;
  logic refetch;
  cpm_mode_type mode_reg;
  cpm_mode_type mode_next;
  logic [1:0] wake_cnt_reg;
  logic irq_path_reg;

  assign ctrl_hit = (i_io_addr == CPM_CTRL_ADDR); // R1
  assign one_shot_arm = i_io_write && ctrl_hit && !i_io_wdata[CPM_BIT_ONE_SHOT]; // R6

  // Writable bits; one-shot bit is not stored
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      fetch_strobe_enable_reg <= CPM_CTRL_RESET[CPM_BIT_FETCH_EN]; // R2
      io_timing_select_reg <= CPM_CTRL_RESET[CPM_BIT_IO_TIMING]; // R7
    end else if (i_io_write && ctrl_hit) begin
      fetch_strobe_enable_reg <= i_io_wdata[CPM_BIT_FETCH_EN];
      io_timing_select_reg <= i_io_wdata[CPM_BIT_IO_TIMING];
    end
  end

  // Read data; one-shot always reads one
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_read && ctrl_hit) begin
      o_io_rdata <= {fetch_strobe_enable_reg, 1'b1, io_timing_select_reg, 5'h00}
                    | CPM_CTRL_RSVD_READ; // R5
    end else begin
      o_io_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Strobe submodules
  // ****************************************
  cpm_fetch_strobe u_fetch (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_fetch_strobe_enable(fetch_strobe_enable_reg),
    .i_one_shot_arm(one_shot_arm),
    .i_halted(mode_reg == CPM_HALT),
    .i_opcode_fetch(i_opcode_fetch),
    .i_irq0_ack(i_irq0_ack),
    .i_nmi_ack_first(i_nmi_ack_first),
    .i_ret_irq_fetch(i_ret_irq_fetch),
    .i_cycle_start(i_cycle_start),
    .o_strobe_n(strobe_n),
    .o_ret_irq_refetch(refetch)
  );

  cpm_io_timing u_io (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_io_timing_select(io_timing_select_reg),
    .i_io_read(i_bus_io_read),
    .i_state_t1_late(i_state_t1_late),
    .i_second_bus_state(i_second_bus_state),
    .o_io_active(io_active)
  );

  // ****************************************
  // Power mode sequencing
  // ****************************************
  // Disabled sources are masked upstream or here; they cannot wake
  assign wake_src = i_onchip_irq || i_nmi_req || |(i_ext_irq & i_ext_irq_en); // R12 R15

  // Peripherals frozen in stop mode cannot wake it; caller gates them
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      CPM_NORMAL: begin
        if (i_halt_exec) begin
          mode_next = CPM_HALT; // R10
        end else if (i_sleep_exec && !i_cpu_control[CPM_BIT_CPU_CTRL3]
                     && !i_cpu_control[CPM_BIT_CPU_CTRL6]) begin
          mode_next = i_io_control[CPM_BIT_FREEZE] ? CPM_STOP : CPM_SLEEP; // R13 R20
        end
      end
      CPM_HALT: begin
        if (wake_src) begin
          mode_next = CPM_NORMAL; // R12
        end
      end
      CPM_SLEEP, CPM_STOP: begin
        if (wake_src) begin
          mode_next = CPM_WAKE; // R15
        end
      end
      CPM_WAKE: begin
        if (wake_cnt_reg == CPM_WAKE_CYCLES - 2'd1) begin
          mode_next = CPM_NORMAL; // R18
        end
      end
      default: begin
        mode_next = CPM_NORMAL;
      end
    endcase
  end

  // Mode register; reset returns to normal from any mode
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mode_reg <= CPM_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Restart delay counter
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || mode_reg != CPM_WAKE) begin
      wake_cnt_reg <= 2'd0;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 2'd1;
    end
  end

  // Capture interrupt-or-continue choice at the wake request
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      irq_path_reg <= 1'b0;
    end else if ((mode_reg == CPM_SLEEP || mode_reg == CPM_STOP) && wake_src) begin
      irq_path_reg <= i_global_irq_enable_flag; // R16 R17
    end
  end

  // One-cycle resume pulses at the end of the restart delay
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_wake_take_irq <= 1'b0;
      o_wake_continue <= 1'b0;
    end else begin
      o_wake_take_irq <= (mode_reg == CPM_WAKE) && (mode_next == CPM_NORMAL)
                         && irq_path_reg; // R16
      o_wake_continue <= (mode_reg == CPM_WAKE) && (mode_next == CPM_NORMAL)
                         && !irq_path_reg; // R17
    end
  end

  // ****************************************
  // Pin levels and clock enables
  // ****************************************
  // Enables follow the next mode so they change with the mode register
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_halt_n <= 1'b1;
      o_core_clk_en <= 1'b1;
      o_dma_clk_en <= 1'b1;
      o_refresh_en <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_clock_out_en <= 1'b1;
      o_bus_hold_high <= 1'b0;
      o_status_output <= 1'b1;
    end else begin
      o_halt_n <= (mode_next == CPM_NORMAL) || (mode_next == CPM_WAKE); // R9 R10 R14
      o_core_clk_en <= (mode_next == CPM_NORMAL) || (mode_next == CPM_HALT); // R11 R14
      o_dma_clk_en <= (mode_next == CPM_NORMAL) || (mode_next == CPM_HALT); // R14
      o_refresh_en <= (mode_next == CPM_NORMAL) || (mode_next == CPM_HALT); // R11 R14
      o_periph_clk_en <= !i_io_control[CPM_BIT_FREEZE] && (mode_next != CPM_STOP); // R19 R20
      o_clock_out_en <= 1'b1; // R11 R20
      o_bus_hold_high <= !i_bus_granted && ((mode_next == CPM_SLEEP)
                         || (mode_next == CPM_STOP)); // R14
      o_status_output <= (mode_next != CPM_HALT); // R10
    end
  end

  // Strobe pins; sleeping bus is held high
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_fetch_cycle_strobe_n <= 1'b1;
      o_io_request_strobe_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_ret_irq_refetch <= 1'b0;
    end else begin
      o_fetch_cycle_strobe_n <= strobe_n || o_bus_hold_high; // R14
      o_io_request_strobe_n <= !io_active || o_bus_hold_high;
      o_read_strobe_n <= !io_active || o_bus_hold_high;
      o_ret_irq_refetch <= refetch;
    end
  end
endmodule : cpm_ctrl

// File: tb/cpm_ctrl_props.sv
module cpm_ctrl_props
  import cpm_pkg::*;
(
  // Clock, reset and inputs
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_read,
  input wire logic [7:0] i_io_control,
  input wire logic [7:0] i_cpu_control,
  input wire logic i_global_irq_enable_flag,
  input wire logic i_halt_exec,
  input wire logic i_sleep_exec,
  input wire logic i_onchip_irq,
  input wire logic i_nmi_req,
  input wire logic [2:0] i_ext_irq,
  input wire logic [2:0] i_ext_irq_en,
  // Outputs watched
  input wire logic [7:0] o_io_rdata,
  input wire logic o_halt_n,
  input wire logic o_status_output,
  input wire logic o_fetch_cycle_strobe_n,
  input wire logic o_core_clk_en,
  input wire logic o_refresh_en,
  input wire logic o_wake_take_irq,
  input wire logic o_wake_continue
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Masked wake request, running core, wake pulse
  wire logic wake = i_onchip_irq | i_nmi_req | (|(i_ext_irq & i_ext_irq_en));
  wire logic run = o_halt_n & o_core_clk_en & !wake;
  wire logic pulse = o_wake_take_irq | o_wake_continue;
  logic halt_seen;
  // Halt remembered until a wake source shows
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || wake) halt_seen <= 1'b0;
    else if (run && i_halt_exec) halt_seen <= 1'b1;
  end
  sequence s_halt_go;
    run && i_halt_exec;
  endsequence
  sequence s_sleep_go;
    run && i_sleep_exec && !i_io_control[CPM_BIT_FREEZE]
      && !i_cpu_control[CPM_BIT_CPU_CTRL3] && !i_cpu_control[CPM_BIT_CPU_CTRL6];
  endsequence
  a_read_ctrl: assert property (i_io_read && i_io_addr == CPM_CTRL_ADDR |=>
    o_io_rdata[6] && o_io_rdata[4:0] == 5'h1f) else $error("ctrl readback");
  a_read_other: assert property (i_io_read && i_io_addr != CPM_CTRL_ADDR |=>
    o_io_rdata == 8'h00) else $error("unmapped read");
  a_halt_entry: assert property (s_halt_go |=> !o_halt_n && !o_status_output
    ##2 !o_fetch_cycle_strobe_n) else $error("halt entry");
  a_halt_exit: assert property (halt_seen && wake |=> o_halt_n)
    else $error("halt exit");
  a_sleep_entry: assert property (s_sleep_go |=> !o_core_clk_en && !o_refresh_en
    && !o_halt_n) else $error("sleep entry");
  a_wake_time: assert property (!o_core_clk_en && !o_refresh_en && wake
    |-> ##[1:4] pulse) else $error("slow wake");
  a_no_wake: assert property ((!wake) [*5] |-> !pulse) else $error("spurious wake");
  a_wake_kind: assert property (pulse |-> o_wake_take_irq == i_global_irq_enable_flag
    && !(o_wake_take_irq && o_wake_continue)) else $error("wake kind");
endmodule : cpm_ctrl_props

bind cpm_ctrl cpm_ctrl_props i_props (.*);

// File: tb/cpm_periph_model.sv
module cpm_periph_model (
  // Watched strobe
  input wire logic i_clock,
  input wire logic i_strobe_n,
  // Strobes seen so far
  output int o_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_n = 1'b1;
  initial o_seen = 0;
  // Latches on each falling strobe, as an old peripheral would
  always @(posedge i_clock) begin
    last_n <= i_strobe_n;
    if (last_n && !i_strobe_n) o_seen <= o_seen + 1;
  end
endmodule : cpm_periph_model

// File: tb/cpm_ctrl_tb.sv
module cpm_ctrl_tb
  import cpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 0, i_sys_rst = 1, i_io_write = 0, i_io_read = 0, i_halt_exec = 0;
  logic i_global_irq_enable_flag = 0, i_sleep_exec = 0, i_bus_granted = 0, s, r;
  logic i_onchip_irq = 0, i_nmi_req = 0, i_opcode_fetch = 0, i_irq0_ack = 0;
  logic i_nmi_ack_first = 0, i_ret_irq_fetch = 0, i_cycle_start = 0, i_bus_io_read = 0;
  logic i_state_t1_late = 0, i_second_bus_state = 0;
  logic [7:0] i_io_addr = 0, i_io_wdata = 0, i_io_control = 0, i_cpu_control = 0;
  logic [7:0] o_io_rdata, sh, a;
  logic [2:0] i_ext_irq = 0, i_ext_irq_en = 0;
  logic o_fetch_cycle_strobe_n, o_io_request_strobe_n, o_read_strobe_n, o_halt_n;
  logic o_status_output, o_bus_hold_high, o_core_clk_en, o_dma_clk_en, o_refresh_en;
  logic o_periph_clk_en, o_clock_out_en, o_ret_irq_refetch, o_wake_take_irq, o_wake_continue;
  int n_mismatch = 0, n_compared = 0, seed = 51, seen, seen0, n;

  cpm_ctrl i_dut (.*);
  cpm_periph_model i_periph (.i_clock(i_clock), .i_strobe_n(o_fetch_cycle_strobe_n),
    .o_seen(seen));

  // 250 MHz clock
  initial forever #2 i_clock = ~i_clock;

  // Expected readback of the control register
  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return {d[CPM_BIT_FETCH_EN], 1'b1, d[CPM_BIT_IO_TIMING], 5'h1f};
  endfunction : ctrl_exp

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk

  // Register port: write, or read with the answer one cycle on
  task automatic acc(input logic wt, input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_clock);
    i_io_addr <= ad;
    i_io_wdata <= d;
    i_io_write <= wt;
    i_io_read <= !wt;
    @(posedge i_clock);
    i_io_write <= 1'b0;
    i_io_read <= 1'b0;
    @(negedge i_clock);
    if (!wt) chk(o_io_rdata === d, 1'b1, "read data");
  endtask : acc

  // Bus cycle; strobe low in either following cycle counts
  task automatic cyc(input logic io, input logic k, output logic sn, output logic rf);
    @(posedge i_clock);
    i_opcode_fetch <= !io;
    i_ret_irq_fetch <= !io && k;
    i_cycle_start <= !io;
    i_bus_io_read <= io;
    i_state_t1_late <= io && !k;
    i_second_bus_state <= io && k;
    @(posedge i_clock);
    {i_cycle_start, i_state_t1_late, i_second_bus_state} <= 3'b000;
    sn = 1'b1;
    rf = 1'b0;
    repeat (2) begin
      @(negedge i_clock);
      sn &= io ? (o_io_request_strobe_n | o_read_strobe_n) : o_fetch_cycle_strobe_n;
      rf |= o_ret_irq_refetch;
    end
    @(posedge i_clock);
    {i_opcode_fetch, i_ret_irq_fetch, i_bus_io_read} <= 3'b000;
  endtask : cyc

  task automatic pulse_exec(input logic sl);
    @(posedge i_clock);
    i_sleep_exec <= sl;
    i_halt_exec <= !sl;
    @(posedge i_clock);
    {i_sleep_exec, i_halt_exec} <= 2'b00;
    repeat (2) @(negedge i_clock);
  endtask : pulse_exec

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    $display("FAIL %0t run too long", $time);
    test_done();
  end

  // ************
  // Main sequence
  // ************
  initial begin
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    sh = CPM_CTRL_RESET;
    acc(0, CPM_CTRL_ADDR, ctrl_exp(sh));
    chk(o_halt_n & o_status_output, 1'b1, "normal operation");
    // Random traffic, unmapped places among it
    repeat (16) begin
      a = ($random(seed) % 3 == 0) ? 8'($random(seed)) : CPM_CTRL_ADDR;
      if (a == CPM_CTRL_ADDR) sh = 8'($random(seed));
      acc(1, a, sh);
      acc(0, a, (a == CPM_CTRL_ADDR) ? ctrl_exp(sh) : 8'h00);
    end
    acc(1, CPM_CTRL_ADDR, 8'he0);
    cyc(0, 0, s, r);
    cyc(0, 1, s, r);
    chk(s | r, 1'b0, "enabled fetch strobe, single return fetch");
    acc(1, CPM_CTRL_ADDR, 8'h60);
    cyc(0, 0, s, r);
    chk(s, 1'b1, "fetch strobe disabled");
    seen0 = seen;
    acc(1, CPM_CTRL_ADDR, 8'h20);
    cyc(0, 0, s, r);
    chk(s, 1'b0, "one-shot strobe");
    cyc(0, 0, s, r);
    chk(s && seen - seen0 == 1, 1'b1, "one-shot spent");
    cyc(0, 1, s, r);
    chk(r, 1'b1, "return refetch");
    cyc(1, 0, s, r);
    chk(s, 1'b0, "newer io timing");
    acc(1, CPM_CTRL_ADDR, 8'h40);
    cyc(1, 0, s, r);
    chk(s, 1'b1, "legacy io early");
    cyc(1, 1, s, r);
    chk(s, 1'b0, "legacy io at second state");
    i_ext_irq <= 3'b001;
    pulse_exec(0);
    repeat (2) @(negedge i_clock);
    chk(o_halt_n | o_status_output, 1'b0, "halted");
    chk(o_refresh_en & o_dma_clk_en & o_clock_out_en, 1'b1, "halt keeps running");
    @(posedge i_clock);
    i_ext_irq_en <= 3'b001;
    repeat (2) @(negedge i_clock);
    chk(o_halt_n, 1'b1, "halt exit");
    @(posedge i_clock);
    {i_ext_irq_en, i_cpu_control} <= {3'b100, 8'h40};
    pulse_exec(1);
    chk(o_core_clk_en, 1'b1, "sleep refused");
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clock);
      {i_onchip_irq, i_nmi_req, i_ext_irq, i_cpu_control} <= {5'b00011, 8'h00};
      i_global_irq_enable_flag <= (i == 0);
      i_io_control <= (i == 2) ? 8'h20 : 8'h00;
      repeat (2) @(negedge i_clock);
      chk(o_periph_clk_en, i != 2, "freeze");
      pulse_exec(1);
      chk(o_core_clk_en | o_dma_clk_en | o_refresh_en | o_halt_n, 1'b0, "asleep");
      chk(o_bus_hold_high & o_clock_out_en, 1'b1, "bus held, clock out");
      repeat (4) @(negedge i_clock);
      chk(o_core_clk_en, 1'b0, "masked source");
      @(posedge i_clock);
      {i_onchip_irq, i_nmi_req, i_ext_irq} <= {i == 0, i == 1, i == 2, 2'b11};
      n = 0;
      do begin
        @(negedge i_clock);
        n++;
      end while (!(o_wake_take_irq | o_wake_continue) && n < 8);
      if (n >= 8) chk(1'b0, 1'b1, "wake timeout");
      if (n >= 8) test_done();
      chk(o_wake_take_irq, i == 0, "wake kind");
      chk(o_wake_continue, i != 0, "wake continue");
      chk(n >= CPM_WAKE_CYCLES && n <= CPM_WAKE_CYCLES + 2, 1'b1, "wake time");
    end
    // Reset in mid-run must leave system stop at once
    @(posedge i_clock);
    {i_onchip_irq, i_nmi_req, i_ext_irq} <= 5'b00000;
    pulse_exec(1);
    chk(o_core_clk_en | o_periph_clk_en, 1'b0, "system stop");
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(negedge i_clock);
    chk(o_halt_n & o_core_clk_en, 1'b1, "reset wakes");
    acc(0, CPM_CTRL_ADDR, ctrl_exp(CPM_CTRL_RESET));
    test_done();
  end
endmodule : cpm_ctrl_tb
